// ==== dv/mpss_chk.sv ====
// Purpose: Port assertions for the step sequencer.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Pulse checks guard against requests that stick high.
`timescale 1ns/100ps
module mpss_chk
(
  // Clock and reset.
  input wire        CLK_I,
  input wire        NRST_I,
  // Watched signals.
  input wire        START_I,
  input wire [31:0] MOVE_DIST_I,
  input wire [2:0]  PROG_IN_I,
  input wire [7:0]  STEP_ADDR_O,
  input wire        MOVE_REQ_O,
  input wire        IPOS_REQ_O,
  input wire [31:0] IPOS_DIST_O,
  input wire        TRIP_ARM_O,
  input wire        BUSY_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  chk_idle_quiet: assert property
    (!BUSY_O |-> !(MOVE_REQ_O || IPOS_REQ_O || TRIP_ARM_O))
    else $error("request while idle");
  chk_idle_addr: assert property
    (!BUSY_O && !START_I |=> $stable(STEP_ADDR_O))
    else $error("address moved while idle");
  chk_idle_stays: assert property
    (!BUSY_O && !START_I |=> !BUSY_O) else $error("woke without start");
  chk_start_taken: assert property
    (!BUSY_O && START_I |-> ##[1:2] BUSY_O) else $error("start lost");
  chk_move_one: assert property
    (MOVE_REQ_O |=> !MOVE_REQ_O) else $error("move pulse too long");
  chk_ipos_one: assert property
    (IPOS_REQ_O |=> !IPOS_REQ_O) else $error("stop pulse too long");
  chk_trip_one: assert property
    (TRIP_ARM_O |=> !TRIP_ARM_O) else $error("trip pulse too long");
  chk_ipos_cause: assert property
    ($rose(IPOS_REQ_O) |-> $past(PROG_IN_I) != 3'h0)
    else $error("interrupt stop without input");
  chk_ipos_fits: assert property
    (IPOS_REQ_O |-> IPOS_DIST_O <= MOVE_DIST_I)
    else $error("interrupt stop not skipped");
endmodule
bind mpss_top mpss_chk mpss_chk_inst (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .START_I(START_I), .MOVE_DIST_I(MOVE_DIST_I), .PROG_IN_I(PROG_IN_I),
  .STEP_ADDR_O(STEP_ADDR_O), .MOVE_REQ_O(MOVE_REQ_O),
  .IPOS_REQ_O(IPOS_REQ_O), .IPOS_DIST_O(IPOS_DIST_O),
  .TRIP_ARM_O(TRIP_ARM_O), .BUSY_O(BUSY_O));

// ==== dv/mpss_motion_model.sv ====
// Purpose: Behavioural motion generator facing the sequencer.
// Assumes: One distance unit travelled per clock.
// Notes:   Remaining distance shows the new move at once, so a dwell
//          right after a move cannot see a stale zero.
`timescale 1ns/100ps
module mpss_motion_model
(
  // Clock and reset.
  input  wire         clk_i,
  input  wire         nrst_i,
  // Requests from the sequencer.
  input  wire         move_req_i,
  input  wire         ipos_req_i,
  input  wire         trip_arm_i,
  input  wire  [31:0] arg_i,
  input  wire  [31:0] ipos_dist_i,
  // Motion state.
  output wire  [31:0] remain_o,
  output logic [31:0] move_dist_o,
  output logic        trip_o
);
  logic [31:0] rem_r;
  logic [7:0]  trip_r;
  assign remain_o = move_req_i ? arg_i : rem_r;
  // Travel, interrupt stop and trip point tracking.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rem_r <= 32'h0;
      move_dist_o <= 32'h0;
      trip_r <= 8'h0;
      trip_o <= 1'b0;
    end
    else
    begin
      if (move_req_i)
      begin
        rem_r <= arg_i - 32'h1;
        move_dist_o <= arg_i;
      end
      else if (ipos_req_i)
        rem_r <= ipos_dist_i;
      else if (rem_r != 32'h0)
        rem_r <= rem_r - 32'h1;
      trip_r <= trip_arm_i ? 8'h14 : (trip_r != 8'h0 ? trip_r - 8'h1 : 8'h0);
      trip_o <= trip_arm_i ? 1'b0 : (trip_o | trip_r == 8'h1);
    end
  end
endmodule

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench of the step sequencer.
// Assumes: Dwell unit shortened to 5 cycles.
// Notes:   Program store answers one cycle after each address.
`timescale 1ns/100ps
`include "mpss_consts.vh"
module tb_top;
  logic clk = 0, nrst = 0, start = 0, pul = 0;
  logic [2:0] pin = 0;
  logic [35:0] data = 0;
  logic [35:0] prog [0:7];
  wire [7:0] addr;
  wire [31:0] rem, mdist, idist, arg;
  wire mreq, ireq, tarm, busy, tpass;
  int n_errors = 0, checks_done = 0, cyc = 0, n_mv = 0, n_ipos = 0;
  int n_trip = 0, t_mv = 0, t_end = 0, b;
  mpss_top #(.DWELL_CYC(5)) mpss_top_inst (.CLK_I(clk), .NRST_I(nrst),
    .START_I(start), .STEP_ADDR_O(addr), .STEP_DATA_I(data),
    .REMAIN_DIST_I(rem), .MOVE_DIST_I(mdist), .TRIP_PASSED_I(tpass),
    .MOVE_REQ_O(mreq), .IPOS_REQ_O(ireq), .IPOS_DIST_O(idist), .ARG_O(arg),
    .TRIP_ARM_O(tarm), .PROG_IN_I(pin), .PULSE_I(pul), .BUSY_O(busy));
  mpss_motion_model mpss_motion_model_inst (.clk_i(clk), .nrst_i(nrst),
    .move_req_i(mreq), .ipos_req_i(ireq), .trip_arm_i(tarm), .arg_i(arg),
    .ipos_dist_i(idist), .remain_o(rem), .move_dist_o(mdist), .trip_o(tpass));
  initial forever #25 clk = ~clk;
  // Program store read and event bookkeeping.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    data <= prog[addr[2:0]];
    n_mv <= n_mv + mreq;
    n_ipos <= n_ipos + ireq;
    n_trip <= n_trip + tarm;
    if (mreq) t_mv <= cyc;
    if ($fell(busy)) t_end <= cyc;
  end
  function [35:0] w(input [3:0] op, input [31:0] a);
    w = {op, a};
  endfunction
  task ld(input [35:0] a, b0, c, d);
    prog = '{a, b0, c, d, w(`MPSS_OP_END, 0), w(4'hF, 0), w(4'hF, 0),
      w(4'hF, 0)};
  endtask
  task cmp(input [31:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wt(input int n);
    for (int i = 0; i < n && busy !== 1'b0; i++) @(posedge clk);
    #1;
  endtask
  task run(input int n);
    @(posedge clk) start <= 1;
    @(posedge clk) start <= 0;
    repeat (2) @(posedge clk);
    wt(n);
  endtask
  task pls(input int n);
    repeat (n)
    begin
      @(posedge clk) pul <= 1;
      @(posedge clk) pul <= 0;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task t_dwell;
    ld(w(1, 10), w(2, 20), w(3, 1), w(4'hF, 0));
    pin <= 3'h1;
    run(400);
    cmp(busy, 0);
    cmp(t_end - t_mv >= 110 && t_end - t_mv <= 125, 1);
    $display("dwell test done");
  endtask
  task t_sync;
    ld(w(3, 2), w(4'hF, 0), w(4'hF, 0), w(4'hF, 0));
    run(30);
    cmp(busy, 1);
    cmp(arg, 2);
    @(posedge clk) pin <= 3'h2;
    wt(20);
    cmp(busy, 0);
    $display("sync test done");
  endtask
  task t_ipos;
    @(posedge clk) pin <= 3'h0;
    b = n_ipos;
    ld(w(1, 200), w(3, 1), w(4, 50), w(4'hF, 0));
    run(20);
    @(posedge clk) pin <= 3'h1;
    wt(300);
    cmp(n_ipos - b, 1);
    cmp(idist, 50);
    b = n_ipos;
    ld(w(1, 30), w(3, 1), w(4, 50), w(4'hF, 0));
    run(300);
    cmp(n_ipos - b, 0);
    cmp(busy, 0);
    $display("interrupt positioning test done");
  endtask
  task t_count;
    pls(5);
    ld(w(5, 0), w(5, 3), w(4'hF, 0), w(4'hF, 0));
    run(10);
    pls(3);
    cmp(busy, 1);
    pls(1);
    wt(20);
    cmp(busy, 0);
    $display("count test done");
  endtask
  task t_loop;
    b = n_mv;
    ld(w(6, 3), w(1, 4), w(7, 0), w(1, 4));
    run(400);
    cmp(n_mv - b, 4);
    cmp(addr, 5);
    b = n_trip;
    ld(w(1, 60), w(8, 20), w(4'hF, 0), w(4'hF, 0));
    run(8);
    cmp(busy, 1);
    wt(40);
    cmp(busy, 0);
    cmp(n_trip - b, 1);
    $display("loop and trip test done");
  endtask
  task close_out;
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Reset, then the scenarios in turn.
  initial
  begin
    ld(w(4'hF, 0), w(4'hF, 0), w(4'hF, 0), w(4'hF, 0));
    repeat (3) @(posedge clk);
    nrst <= 1;
    t_dwell;
    t_sync;
    t_ipos;
    t_count;
    t_loop;
    close_out;
  end
  // Watchdog cuts a hang short well past the expected run length.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out;
  end
endmodule

// ==== logic/mpss_consts.vh ====
// Purpose: Constants of the motion program step sequencer.
// Assumes: 20 MHz clock, one program step word per fetch.
// Notes:   Opcodes are local to this sequencer's program store.
`ifndef MPSS_CONSTS_VH
`define MPSS_CONSTS_VH
// Clock rate and the dwell unit.
`define MPSS_CLK_HZ       20000000
`define MPSS_DWELL_UNIT_MS 10
`define MPSS_DWELL_UNIT_CYC ((`MPSS_CLK_HZ / 1000) * `MPSS_DWELL_UNIT_MS)
// Opcode field of a step word.
`define MPSS_OP_MSB      35
`define MPSS_OP_LSB      32
`define MPSS_OP_NOP      4'h0
`define MPSS_OP_MOVE     4'h1
`define MPSS_OP_DWELL    4'h2
`define MPSS_OP_SYNC     4'h3
`define MPSS_OP_IPOS     4'h4
`define MPSS_OP_COUNT    4'h5
`define MPSS_OP_FOR      4'h6
`define MPSS_OP_NEXT     4'h7
`define MPSS_OP_TRIP     4'h8
`define MPSS_OP_END      4'hF
// Argument field of a step word.
`define MPSS_ARG_MSB     31
`define MPSS_ARG_LSB     0
// Reset values.
`define MPSS_PC_RST      8'h00
`endif

// ==== logic/mpss_dwell_timer.v ====
// Purpose: Dwell timer counting in whole dwell units.
// Assumes: Start is a one-cycle pulse carrying the unit count.
// Notes:   A count of zero finishes on the cycle after start.
`timescale 1ns/100ps
`include "mpss_consts.vh"
module mpss_dwell_timer
#(
  parameter UNIT_CYC = `MPSS_DWELL_UNIT_CYC
)
(
  // Clock and reset.
  input  wire        clk_i,
  input  wire        nrst_i,
  // Control.
  input  wire        start_i,
  input  wire [31:0] units_i,
  // Status.
  output wire        done_o
);
  reg [31:0] units_r;
  reg [31:0] pre_r;
  reg        busy_r;

  // Prescaler divides the clock to dwell units; units count down.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      units_r <= 32'h0;
      pre_r   <= 32'h0;
      busy_r  <= 1'b0;
    end
    else if (start_i)
    begin
      units_r <= units_i;
      pre_r   <= 32'h0;
      busy_r  <= 1'b1;
    end
    else if (busy_r)
    begin
      if (units_r == 32'h0)
        busy_r <= 1'b0;
      else if (pre_r == UNIT_CYC - 1)
      begin
        pre_r   <= 32'h0;
        units_r <= units_r - 32'h1;
      end
      else
        pre_r <= pre_r + 32'h1;
    end
  end

  assign done_o = busy_r && (units_r == 32'h0);
endmodule

// ==== logic/mpss_top.v ====
// Purpose: Step sequencer of a positioning program.
// Assumes: Motion generator reports remaining distance and stops itself.
// Notes:   One program loop level; motion is only requested here.
// Contract
// - A dwell waits for zero remaining distance, then for its time.
// - Dwell counts in 10 ms units, so a later sync sees input after it.
// - A sync step holds until its selected program input is high.
// - Interrupt positioning stops the set distance past the input edge.
// - Interrupt positioning is skipped when the move is shorter than it.
// - Short interrupt distance still stops there with shorter deceleration.
// - The stop point depends on speed when the interrupt command activates.
// - A count step holds until the pulse count exceeds its setting.
// - A count step of zero clears the accumulated pulse count.
// - Steps of a repeat loop run the set number of times, then go on; a setting of zero runs them once.
// - A trip step holds until the axis passes the set point.
`timescale 1ns/100ps
`include "mpss_consts.vh"
module mpss_top
#(
  parameter AW        = 8,
  parameter DWELL_CYC = `MPSS_DWELL_UNIT_CYC
)
(
  // Clock and reset.
  input  wire          CLK_I,
  input  wire          NRST_I,
  // Program start and store.
  input  wire          START_I,
  output reg  [AW-1:0] STEP_ADDR_O,
  input  wire [35:0]   STEP_DATA_I,
  // Motion generator.
  input  wire [31:0]   REMAIN_DIST_I,
  input  wire [31:0]   MOVE_DIST_I,
  input  wire          TRIP_PASSED_I,
  output reg           MOVE_REQ_O,
  output reg           IPOS_REQ_O,
  output reg  [31:0]   IPOS_DIST_O,
  output reg  [31:0]   ARG_O,
  output reg           TRIP_ARM_O,
  // Program inputs and pulse generator.
  input  wire [2:0]    PROG_IN_I,
  input  wire          PULSE_I,
  // Status.
  output wire          BUSY_O
);
  // States, one-hot.
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_FETCH = 7'h02;
  localparam [6:0] S_EXEC  = 7'h04;
  localparam [6:0] S_DWAIT = 7'h08;
  localparam [6:0] S_DTIME = 7'h10;
  localparam [6:0] S_HOLD  = 7'h20;
  localparam [6:0] S_IPOSW = 7'h40;

  reg [6:0]    state_r;
  reg [AW-1:0] loop_start_r;
  reg [31:0]   loop_cnt_r;
  reg          in_loop_r;
  reg [31:0]   pulse_cnt_r;
  reg [31:0]   count_set_r;
  reg [2:0]    sync_sel_r;
  reg [3:0]    hold_op_r;
  reg          pulse_clr_r;
  reg          dwell_go_r;

  // Step increment at the address width, so no bits are dropped.
  localparam [AW-1:0] ADDR_ONE = {{(AW-1){1'b0}}, 1'b1};

  wire [3:0]  op  = STEP_DATA_I[`MPSS_OP_MSB:`MPSS_OP_LSB];
  wire [31:0] arg = STEP_DATA_I[`MPSS_ARG_MSB:`MPSS_ARG_LSB];
  wire        dwell_done;

  assign BUSY_O = (state_r != S_IDLE);

  // True when the step at hand may release the hold.
  function hold_ok;
    input [3:0]  hop;
    input [2:0]  sel;
    input [2:0]  pin;
    input [31:0] pcnt;
    input [31:0] pset;
    input        trip;
    begin
      case (hop)
        `MPSS_OP_SYNC:  hold_ok = |(sel & pin);
        `MPSS_OP_COUNT: hold_ok = (pcnt > pset);
        `MPSS_OP_TRIP:  hold_ok = trip;
        default:        hold_ok = 1'b1;
      endcase
    end
  endfunction

  mpss_dwell_timer
  #(
    .UNIT_CYC (DWELL_CYC)
  )
  u_dwell
  (
    .clk_i   (CLK_I),
    .nrst_i  (NRST_I),
    .start_i (dwell_go_r),
    .units_i (count_set_r),
    .done_o  (dwell_done)
  );

  // Pulse accumulator; a clear and a pulse together leave one count.
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      pulse_cnt_r <= 32'h0;
    else if (pulse_clr_r)
      pulse_cnt_r <= PULSE_I ? 32'h1 : 32'h0;
    else if (PULSE_I)
      pulse_cnt_r <= pulse_cnt_r + 32'h1;
  end

  // Main sequencer. Each step is one fetch cycle and one execute cycle, plus wait states for dwell, sync, count, trip and interrupt steps.
  always @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      state_r      <= S_IDLE;
      STEP_ADDR_O  <= `MPSS_PC_RST;
      loop_start_r <= {AW{1'b0}};
      loop_cnt_r   <= 32'h0;
      in_loop_r    <= 1'b0;
      count_set_r  <= 32'h0;
      sync_sel_r   <= 3'h0;
      hold_op_r    <= `MPSS_OP_NOP;
      MOVE_REQ_O   <= 1'b0;
      IPOS_REQ_O   <= 1'b0;
      IPOS_DIST_O  <= 32'h0;
      ARG_O        <= 32'h0;
      TRIP_ARM_O   <= 1'b0;
      pulse_clr_r  <= 1'b0;
      dwell_go_r   <= 1'b0;
    end
    else
    begin
      MOVE_REQ_O  <= 1'b0;
      IPOS_REQ_O  <= 1'b0;
      TRIP_ARM_O  <= 1'b0;
      pulse_clr_r <= 1'b0;
      dwell_go_r  <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (START_I)
          begin
            STEP_ADDR_O <= `MPSS_PC_RST;
            in_loop_r   <= 1'b0;
            state_r     <= S_FETCH;
          end
        end
        S_FETCH:
          state_r <= S_EXEC;
        S_EXEC:
        begin
          ARG_O       <= arg;
          STEP_ADDR_O <= STEP_ADDR_O + ADDR_ONE;
          state_r     <= S_FETCH;
          case (op)
            `MPSS_OP_MOVE:
              MOVE_REQ_O <= 1'b1;
            `MPSS_OP_DWELL:
            begin
              count_set_r <= arg;
              state_r     <= S_DWAIT;
            end
            `MPSS_OP_SYNC:
            begin
              sync_sel_r <= arg[2:0];
              hold_op_r  <= op;
              state_r    <= S_HOLD;
            end
            `MPSS_OP_IPOS:
            begin
              // A move shorter than the interrupt distance skips it.
              if (MOVE_DIST_I >= arg)
              begin
                sync_sel_r  <= 3'h7;
                IPOS_DIST_O <= arg;
                state_r     <= S_IPOSW;
              end
            end
            `MPSS_OP_COUNT:
            begin
              count_set_r <= arg;
              if (arg == 32'h0)
                pulse_clr_r <= 1'b1;
              else
              begin
                hold_op_r <= op;
                state_r   <= S_HOLD;
              end
            end
            `MPSS_OP_TRIP:
            begin
              TRIP_ARM_O <= 1'b1;
              hold_op_r  <= op;
              state_r    <= S_HOLD;
            end
            `MPSS_OP_FOR:
            begin
              // Single loop level: a nested start overwrites the outer one.
              loop_start_r <= STEP_ADDR_O + ADDR_ONE;
              loop_cnt_r   <= arg;
              in_loop_r    <= (arg > 32'h1);
            end
            `MPSS_OP_NEXT:
            begin
              if (in_loop_r && loop_cnt_r > 32'h1)
              begin
                loop_cnt_r  <= loop_cnt_r - 32'h1;
                STEP_ADDR_O <= loop_start_r;
                in_loop_r   <= (loop_cnt_r > 32'h2);
              end
              else
                in_loop_r <= 1'b0;
            end
            `MPSS_OP_END:
              state_r <= S_IDLE;
            default:
              state_r <= S_FETCH;
          endcase
        end
        S_DWAIT:
        begin
          // Dwell time starts only once the move has run out.
          if (REMAIN_DIST_I == 32'h0)
          begin
            dwell_go_r <= 1'b1;
            state_r  <= S_DTIME;
          end
        end
        S_DTIME:
        begin
          if (dwell_done && !dwell_go_r)
            state_r <= S_FETCH;
        end
        S_HOLD:
        begin
          if (hold_ok(hold_op_r, sync_sel_r, PROG_IN_I,
                      pulse_cnt_r, count_set_r, TRIP_PASSED_I))
            state_r <= S_FETCH;
        end
        S_IPOSW:
        begin
          // The generator itself decelerates, shortening the ramp if the
          // distance is too short; the stop depends on speed at this edge.
          if (|PROG_IN_I)
          begin
            IPOS_REQ_O <= 1'b1;
            state_r   <= S_DWAIT;
            count_set_r <= 32'h0;
          end
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end
endmodule
